/* hw/bwdt_top.v */
// Purpose: Programmable watchdog with seconds or minutes time base.
// Assumes: Single 10 MHz clock; software on a plain register port.
// Notes: Writing a non-zero factor both enables and triggers.
//
// Notes on behaviour
// - System reset leaves watchdog disabled, no reset.
// - Non-zero factor byte write enables and loads period.
// - Trigger write reloads counter, restarts countdown.
// - Expiry while enabled emits system reset pulse.
// - Factor 1..FF; period is factor times unit.
// - Time base selectable: seconds or minutes.
// - Seconds unit is about one second.
// - LED blinks while counting, dark when disabled.
// - Disabling before expiry stops countdown, no reset.
// - Writing zero disables watchdog and blinking.
// - New non-zero factor replaces period immediately.
`timescale 1ns/1ps
`include "bwdt_defs.vh"
module bwdt_top #(
    parameter SEC_CYCLES = `BWDT_CLK_HZ,
    parameter MIN_SECONDS = `BWDT_SEC_PER_MIN,
    parameter BLINK_CYCLES = `BWDT_CLK_HZ / 1000 * `BWDT_BLINK_HALF_MS,
    parameter RST_CYCLES = `BWDT_RST_CYCLES
) (
    // Clock, reset and freeze
    input wire clock,
    input wire srst,
    input wire ce,
    // Register port
    input wire [`BWDT_ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata,
    // System side
    output reg wdt_reset,
    output reg led,
    output reg irq
);
    localparam BASE_W = 32;
    localparam integer MIN_TOP_I = MIN_SECONDS - 1;
    localparam integer RST_LAST_I = RST_CYCLES - 1;
    localparam [7:0] MIN_TOP = MIN_TOP_I[7:0];
    localparam [31:0] BLINK_LAST = BLINK_CYCLES - 1;
    localparam [7:0] RST_LAST = RST_LAST_I[7:0];

    reg enabled_q;
    reg min_unit_q;
    reg [7:0] factor_q;
    reg [7:0] count_q;
    reg [7:0] sub_q;
    reg [7:0] rst_cnt_q;
    reg [31:0] blink_cnt_q;
    reg [`BWDT_NUM_EV-1:0] ev_stat_q;
    reg [`BWDT_NUM_EV-1:0] ev_mask_q;
    reg [`BWDT_NUM_EV-1:0] ev_d;
    wire sec_tick;
    wire wr_factor;
    wire rd_irq_stat;
    wire expire;
    wire unit_end;

    assign wr_factor = wr_stb && (addr == `BWDT_A_FACTOR);
    assign rd_irq_stat = rd_stb && (addr == `BWDT_A_IRQ_STAT);

    // The second divider restarts on each factor write so a trigger
    // always buys a full unit, never a partly elapsed one.
    bwdt_tick #(
        .CYCLES(SEC_CYCLES),
        .CW(BASE_W)
    ) u_tick (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .restart(wr_factor),
        .run(enabled_q),
        .tick(sec_tick)
    );

    // In minute mode a unit ends after a full minute of second ticks.
    assign unit_end = sec_tick && (!min_unit_q || sub_q == MIN_TOP);
    assign expire = enabled_q && unit_end && count_q == 8'h01;

    // Countdown, enable and time base.
    always @(posedge clock) begin
        if (srst) begin
            enabled_q <= 1'b0;
            factor_q <= `BWDT_FACTOR_OFF;
            count_q <= 8'h00;
            sub_q <= 8'h00;
            min_unit_q <= 1'b0;
        end else if (ce) begin
            if (wr_stb && addr == `BWDT_A_CTRL) begin
                min_unit_q <= wdata[`BWDT_CTRL_MIN_BIT];
            end
            if (wr_factor) begin
                factor_q <= wdata;
                count_q <= wdata;
                sub_q <= 8'h00;
                enabled_q <= (wdata != `BWDT_FACTOR_OFF);
            end else if (expire) begin
                enabled_q <= 1'b0;
                count_q <= 8'h00;
            end else if (enabled_q && sec_tick) begin
                if (unit_end) begin
                    sub_q <= 8'h00;
                    count_q <= count_q - 8'h01;
                end else begin
                    sub_q <= sub_q + 8'h01;
                end
            end
        end
    end

    // Reset pulse of fixed length; factor write cannot cut it short.
    always @(posedge clock) begin
        if (srst) begin
            wdt_reset <= 1'b0;
            rst_cnt_q <= 8'h00;
        end else if (ce) begin
            if (expire) begin
                wdt_reset <= 1'b1;
                rst_cnt_q <= 8'h00;
            end else if (wdt_reset) begin
                if (rst_cnt_q == RST_LAST) begin
                    wdt_reset <= 1'b0;
                end else begin
                    rst_cnt_q <= rst_cnt_q + 8'h01;
                end
            end
        end
    end

    // Indicator blink; dark whenever the watchdog is disabled.
    always @(posedge clock) begin
        if (srst) begin
            led <= 1'b0;
            blink_cnt_q <= 32'h00000000;
        end else if (ce) begin
            if (!enabled_q) begin
                led <= 1'b0;
                blink_cnt_q <= 32'h00000000;
            end else if (blink_cnt_q == BLINK_LAST) begin
                led <= ~led;
                blink_cnt_q <= 32'h00000000;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h00000001;
            end
        end
    end

    // Event capture; a new event wins over a read-clear in one cycle.
    always @* begin
        ev_d = ev_stat_q;
        if (rd_irq_stat) begin
            ev_d = {`BWDT_NUM_EV{1'b0}};
        end
        if (expire) begin
            ev_d[`BWDT_EV_EXPIRE] = 1'b1;
        end
        if (wr_factor && wdata != `BWDT_FACTOR_OFF) begin
            ev_d[`BWDT_EV_TRIGGER] = 1'b1;
        end
        if (wr_factor && wdata == `BWDT_FACTOR_OFF && enabled_q) begin
            ev_d[`BWDT_EV_DISABLE] = 1'b1;
        end
    end

    // Registers, read port and interrupt line.
    always @(posedge clock) begin
        if (srst) begin
            ev_stat_q <= {`BWDT_NUM_EV{1'b0}};
            ev_mask_q <= {`BWDT_NUM_EV{1'b0}};
            rdata <= 8'h00;
            irq <= 1'b0;
        end else if (ce) begin
            ev_stat_q <= ev_d;
            irq <= |(ev_d & ev_mask_q);
            if (wr_stb && addr == `BWDT_A_IRQ_MASK) begin
                ev_mask_q <= wdata[`BWDT_NUM_EV-1:0];
                irq <= |(ev_d & wdata[`BWDT_NUM_EV-1:0]);
            end
            rdata <= 8'h00;
            if (rd_stb) begin
                case (addr)
                    `BWDT_A_FACTOR: rdata <= factor_q;
                    `BWDT_A_CTRL: rdata <= {7'h00, min_unit_q};
                    `BWDT_A_STATUS: rdata <= {5'h00, led, wdt_reset,
                        enabled_q};
                    `BWDT_A_IRQ_STAT: rdata <= {5'h00, ev_stat_q};
                    `BWDT_A_IRQ_MASK: rdata <= {5'h00, ev_mask_q};
                    `BWDT_A_COUNT: rdata <= count_q;
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

/* hw/bwdt_defs.vh */
// Purpose: Shared constants for the board watchdog timer.
// Assumes: 10 MHz clock, 8-bit register port.
// Notes: Offsets are byte indices on the plain register port.
`ifndef BWDT_DEFS_VH
`define BWDT_DEFS_VH
`define BWDT_ADDR_W 4
`define BWDT_A_FACTOR 4'h0
`define BWDT_A_CTRL 4'h1
`define BWDT_A_STATUS 4'h2
`define BWDT_A_IRQ_STAT 4'h3
`define BWDT_A_IRQ_MASK 4'h4
`define BWDT_A_COUNT 4'h5
`define BWDT_CTRL_MIN_BIT 0
`define BWDT_FACTOR_OFF 8'h00
`define BWDT_CLK_HZ 10000000
`define BWDT_SEC_PER_MIN 60
`define BWDT_BLINK_HALF_MS 250
`define BWDT_RST_CYCLES 16
`define BWDT_EV_EXPIRE 0
`define BWDT_EV_TRIGGER 1
`define BWDT_EV_DISABLE 2
`define BWDT_NUM_EV 3
`endif

/* hw/bwdt_tick.v */
// Purpose: Divides the system clock into a one-cycle tick per time unit.
// Assumes: Restarted whenever the countdown is reloaded.
// Notes: A restart keeps the first unit a full unit long.
`timescale 1ns/1ps
module bwdt_tick #(
    parameter CYCLES = 10,
    parameter CW = 24
) (
    // Clock and control
    input wire clock,
    input wire srst,
    input wire ce,
    input wire restart,
    input wire run,
    // Tick
    output reg tick
);
    localparam integer LAST_I = CYCLES - 1;
    localparam [CW-1:0] LAST = LAST_I[CW-1:0];
    reg [CW-1:0] cnt_q;
    always @(posedge clock) begin
        if (srst) begin
            cnt_q <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (restart || !run) begin
                cnt_q <= {CW{1'b0}};
            end else if (cnt_q == LAST) begin
                cnt_q <= {CW{1'b0}};
                tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

/* sim/bwdt_asserts.sv */
// Purpose: Port checks for bwdt_top.
// Assumes: Checks other than chk_reset_quiet pause while ce is low, as all state is frozen then.
// Notes: Pulse width is counted, as it is too long to unroll.
`timescale 1ns/1ps
module bwdt_asserts #(
    parameter RST_CYCLES = 16
) (
    // Watched ports
    input wire clock,
    input wire srst,
    input wire ce,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] rdata,
    input wire wdt_reset,
    input wire led,
    input wire irq
);
    reg [7:0] hi_q;
    wire fw = wr_stb && addr == 4'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (srst || !ce);
    always @(posedge clock) hi_q <= wdt_reset ? hi_q + 8'h01 : 8'h00;
    chk_reset_quiet: assert property (disable iff (1'b0)
        srst |=> !wdt_reset && !led && !irq) else $error("busy in reset");
    chk_factor_back: assert property (fw ##2 rd_stb && addr == 4'h0
        |=> rdata == $past(wdata, 3)) else $error("factor readback");
    chk_zero_quiet: assert property (fw && wdata == 8'h00
        && !wdt_reset |=> ##1 (!wdt_reset && !led) [*8])
        else $error("runs when off");
    chk_pulse_len: assert property ($fell(wdt_reset)
        |-> hi_q == RST_CYCLES && !led) else $error("pulse length");
    chk_blink_on: assert property (fw && wdata != 8'h00
        ##1 !wr_stb [*6] |-> ##[0:6] led) else $error("no blink");
    chk_read_idle: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("rdata held");
    chk_read_hole: assert property (rd_stb && addr > 4'h5
        |=> rdata == 8'h00) else $error("unmapped read");
    chk_irq_clear: assert property (rd_stb && addr == 4'h3
        ##1 !wr_stb [*3] |-> !irq) else $error("irq stays");
    cover property ($rose(wdt_reset));
    cover property ($rose(irq));
    cover property (wr_stb && addr == 4'h1 && wdata[0]);
endmodule
bind bwdt_top bwdt_asserts #(.RST_CYCLES(RST_CYCLES)) i_chk (.clock(clock),
    .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .wdt_reset(wdt_reset), .led(led),
    .irq(irq));

/* sim/test_board_watchdog_timer.sv */
// Purpose: Directed test of the board watchdog.
// Assumes: Short unit counts so expiries take tens of cycles.
// Notes: Expiry time is checked in a small window, not to the cycle.
`timescale 1ns/1ps
module test_board_watchdog_timer;
    reg clock = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
    reg ce = 1'b1;
    reg [3:0] addr = 4'h0;
    reg [7:0] wdata = 8'h00;
    wire [7:0] rdata;
    wire wdt_reset, led, irq;
    integer err_total = 0, total_checks = 0, n;
    bwdt_top #(.SEC_CYCLES(10), .MIN_SECONDS(3), .BLINK_CYCLES(4),
        .RST_CYCLES(16)) i_dut (.clock(clock), .srst(srst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .wdt_reset(wdt_reset), .led(led), .irq(irq));
    task check(input logic [31:0] s, input logic [31:0] e, input string nm);
        total_checks = total_checks + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("wrong value %s exp %0h seen %0h", nm, e, s);
        end
    endtask
    task wr(input [3:0] a, input [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    // The mask hides status bits that move on their own, such as the LED.
    task rd(input [3:0] a, input [7:0] m, input [7:0] e, input string nm);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(negedge clock);
        check(rdata & m, e, nm);
    endtask
    task to_exp(input integer lo, input integer hi);
        n = 0;
        while (wdt_reset !== 1'b1 && n < 400) begin
            @(negedge clock);
            n = n + 1;
        end
        check(n >= lo && n <= hi, 1'b1, "expiry time");
        n = 0;
        while (wdt_reset === 1'b1 && n < 40) begin
            @(negedge clock);
            n = n + 1;
        end
        check(n, 16, "pulse length");
    endtask
    task stop_test;
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial forever #50 clock = ~clock;
    initial begin
        repeat (3000) @(posedge clock);
        err_total = err_total + 1;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        rd(4'h2, 8'h07, 8'h00, "status");
        wr(4'h4, 8'h01);
        wr(4'h0, 8'h03);
        rd(4'h0, 8'hFF, 8'h03, "factor");
        rd(4'h5, 8'hFF, 8'h03, "count");
        repeat (4) begin
            repeat (24) @(posedge clock);
            wr(4'h0, 8'h03);
        end
        rd(4'h5, 8'hFF, 8'h03, "reload");
        rd(4'h2, 8'h03, 8'h01, "still on");
        wr(4'h0, 8'h02);
        to_exp(20, 23);
        check(irq, 1'b1, "irq");
        rd(4'h3, 8'h01, 8'h01, "irq stat");
        rd(4'h2, 8'h03, 8'h00, "off");
        check(irq, 1'b0, "irq clear");
        wr(4'h0, 8'h05);
        repeat (5) @(posedge clock);
        wr(4'h0, 8'h01);
        to_exp(10, 13);
        wr(4'h4, 8'h00);
        wr(4'h1, 8'h01);
        wr(4'h0, 8'h01);
        to_exp(30, 33);
        check(irq, 1'b0, "masked irq");
        rd(4'h3, 8'h01, 8'h01, "expiry stat");
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h02);
        repeat (6) @(posedge clock);
        rd(4'h2, 8'h07, 8'h05, "led lit");
        wr(4'h0, 8'h00);
        repeat (40) @(posedge clock);
        rd(4'h3, 8'h07, 8'h06, "no expiry");
        rd(4'h2, 8'h07, 8'h00, "stopped");
        rd(4'hF, 8'hFF, 8'h00, "unmapped");
        wr(4'h0, 8'h02);
        @(posedge clock);
        ce <= 1'b0;
        repeat (40) @(posedge clock);
        ce <= 1'b1;
        rd(4'h5, 8'hFF, 8'h02, "frozen count");
        rd(4'h2, 8'h03, 8'h01, "frozen on");
        wr(4'h0, 8'h00);
        stop_test;
    end
endmodule
